// [common/notch_pkg.sv]
/*
  Package for the notch filter coefficient register bank: offsets, field
  positions, widths, reset values and the carrier structs.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package notch_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [7:0]  IDX_A0_HIGH   = 8'h1b;
  localparam logic [7:0]  IDX_A0_LOW    = 8'h1c;
  localparam logic [7:0]  IDX_A1_HIGH   = 8'h1d;
  localparam logic [7:0]  IDX_A1_LOW    = 8'h1e;
  localparam logic [7:0]  IDX_STATUS    = 8'h1f;
  localparam int          ADDR_W        = 10;
  localparam int          WORD_SHIFT    = 2;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int          REG_W         = 9;
  localparam int          COMMIT_BIT    = 8;
  localparam int          ENABLE_BIT    = 7;
  localparam int          HALF_W        = 7;
  localparam int          COEF_W        = 14;
  localparam int          NUM_REGS      = 4;
  localparam logic [8:0]  REG_RESET     = 9'h000;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  localparam int          STAT_PEND_BIT = 0;
  localparam int          STAT_EN_BIT   = 1;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic                  enable;
    logic [COEF_W-1:0]     coef_zero;
    logic [COEF_W-1:0]     coef_one;
  } notch_set_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ADDR_W-1:0]     paddr;
    logic [31:0]           pwdata;
  } apb_req_t;

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } apb_rsp_t;

endpackage : notch_pkg

// [core/notch_coef_shadow_regs.sv]
/*
  Notch filter control register bank with staged (pending) values and a
  write-only commit bit in each coefficient register that moves all staged values into
  the active filter set at once.
  Assumes one clock ref_clk, asynchronous active-low rst_n, an APB master,
  and a one-cycle sample_tick pulse from the audio datapath on the same clock.
*/
// Our own choice: the APB register port.
`timescale 1ns/10ps
// Operation
// [RULE_01] A notch enable bit bypasses the filter at 0, activates it at 1, and resets to 0.
// [RULE_02] The 14-bit coefficient zero keeps bits 13..7 in the first register, 6..0 in the second.
// [RULE_03] The 14-bit coefficient one keeps bits 13..7 in the third register, 6..0 in the fourth.
// [RULE_04] A write with commit clear only stages the value; the active set stays unchanged.
// [RULE_05] A write with commit set activates its own value and all staged values together.
// [RULE_06] The commit bit acts only at the write and is never stored or read back.
// [RULE_07] Committed values enter the active set only between audio samples.
module notch_coef_shadow_regs
  import notch_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire notch_pkg::apb_req_t apb_req,
  output notch_pkg::apb_rsp_t      apb_rsp,
  input  wire logic                sample_tick,
  output notch_pkg::notch_set_t    active_set,
  output logic                     commit_pending
);
  import notch_pkg::*;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Word index of a byte address
  function automatic logic [7:0] word_index(
    input logic [ADDR_W-1:0] a
  );
    word_index = 8'(a >> WORD_SHIFT);
  endfunction : word_index

  // Aligned hit on one register index
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0]        idx
  );
    hit = (word_index(a) == idx) && (a[WORD_SHIFT-1:0] == 2'h0);
  endfunction : hit

  // Joins a high and a low half into one coefficient
  function automatic logic [COEF_W-1:0] join_coef(
    input logic [HALF_W:0] hi,
    input logic [HALF_W:0] lo
  );
    join_coef = {hi[HALF_W-1:0], lo[HALF_W-1:0]};
  endfunction : join_coef

  // Forms a complete filter set from four staged registers
  function automatic notch_set_t build_set(
    input logic [HALF_W:0] r0,
    input logic [HALF_W:0] r1,
    input logic [HALF_W:0] r2,
    input logic [HALF_W:0] r3
  );
    notch_set_t s;
    s.enable    = r0[ENABLE_BIT];                                      // [RULE_01]
    s.coef_zero = join_coef(r0, r1);                                   // [RULE_02]
    s.coef_one  = join_coef(r2, r3);                                   // [RULE_03]
    build_set   = s;
  endfunction : build_set

  // Read view of one staged register; the commit bit reads back as zero
  function automatic logic [31:0] stage_word(
    input logic [HALF_W:0] v
  );
    logic [31:0] w;
    w           = RDATA_ZERO;
    w[HALF_W:0] = v;
    stage_word  = w;
  endfunction : stage_word

  // ==========================================================================
  // Bus phase decode
  // ==========================================================================
  logic                 setup_ph;
  logic                 access_ph;
  logic                 rd_setup;
  logic                 wr_access;

  always_comb begin
    setup_ph  = apb_req.psel && !apb_req.penable;
    access_ph = apb_req.psel && apb_req.penable;
    rd_setup  = setup_ph && !apb_req.pwrite;
    wr_access = access_ph && apb_req.pwrite;
  end

  // ==========================================================================
  // Register select
  // ==========================================================================
  logic [NUM_REGS-1:0]  sel;
  logic                 sel_status;
  logic                 sel_notch;
  logic                 mapped;

  always_comb begin
    sel[0]     = hit(apb_req.paddr, IDX_A0_HIGH);
    sel[1]     = hit(apb_req.paddr, IDX_A0_LOW);
    sel[2]     = hit(apb_req.paddr, IDX_A1_HIGH);
    sel[3]     = hit(apb_req.paddr, IDX_A1_LOW);
    sel_status = hit(apb_req.paddr, IDX_STATUS);
    sel_notch  = |sel;
    mapped     = sel_notch || sel_status;
  end

  // ==========================================================================
  // Write data fields
  // ==========================================================================
  logic                 wr_commit;
  logic [HALF_W:0]      wr_half;

  always_comb begin
    wr_commit = apb_req.pwdata[COMMIT_BIT];
    wr_half   = apb_req.pwdata[HALF_W:0];
  end

  // ==========================================================================
  // Write strobes
  // ==========================================================================
  logic [NUM_REGS-1:0]  wr_stage;
  logic [NUM_REGS-1:0]  commit_hit;
  logic                 commit_now;

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      wr_stage[i]   = wr_access && sel[i];
      commit_hit[i] = wr_stage[i] && wr_commit;                        // [RULE_05]
    end

    // Any of the four registers may carry the commit
    commit_now = |commit_hit;                                          // [RULE_05] [RULE_06]
  end

  // ==========================================================================
  // Staged values
  // ==========================================================================
  // Commit bit is dropped here, so it is never stored
  logic [HALF_W:0]      stage_r   [NUM_REGS];
  logic [HALF_W:0]      stage_nxt [NUM_REGS];

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      stage_nxt[i] = stage_r[i];
      if (wr_stage[i]) begin
        stage_nxt[i] = wr_half;                                        // [RULE_04] [RULE_06]
      end
    end
  end

  // Reset clears every staged half and the staged enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        stage_r[i] <= REG_RESET[HALF_W:0];
      end
    end else begin
      stage_r <= stage_nxt;
    end
  end

  // ==========================================================================
  // Commit snapshot
  // ==========================================================================
  // Taken at the commit write, so later staged writes wait for the next commit
  notch_set_t           snap_r;
  notch_set_t           snap_nxt;

  always_comb begin
    snap_nxt = snap_r;
    if (commit_now) begin
      snap_nxt = build_set(stage_nxt[0],                               // [RULE_05]
                           stage_nxt[1],
                           stage_nxt[2],
                           stage_nxt[3]);
    end
  end

  // Snapshot resets to the disabled, all-zero set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= '0;
    end else begin
      snap_r <= snap_nxt;
    end
  end

  // ==========================================================================
  // Apply strobe
  // ==========================================================================
  logic                 apply_now;

  always_comb begin
    apply_now = req_r && sample_tick;                                  // [RULE_07]
  end

  // ==========================================================================
  // Commit request
  // ==========================================================================
  logic                 req_r;
  logic                 req_nxt;

  always_comb begin
    req_nxt = req_r;

    if (apply_now) begin
      req_nxt = 1'b0;
    end
    // A new commit in the apply cycle wins and waits for the next tick
    if (commit_now) begin
      req_nxt = 1'b1;                                                  // [RULE_05]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // ==========================================================================
  // Active filter set
  // ==========================================================================
  // Changes only on an applied commit
  notch_set_t           set_r;
  notch_set_t           set_nxt;

  always_comb begin
    set_nxt = set_r;                                                   // [RULE_04]
    if (apply_now) begin
      set_nxt = snap_r;                                                // [RULE_07]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      set_r <= '0;                                                     // [RULE_01]
    end else begin
      set_r <= set_nxt;
    end
  end

  // ==========================================================================
  // Status word
  // ==========================================================================
  logic [31:0]          status_word;

  always_comb begin
    status_word                = RDATA_ZERO;
    status_word[STAT_PEND_BIT] = req_r;
    status_word[STAT_EN_BIT]   = set_r.enable;
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [31:0]          rd_val;
  logic [31:0]          rdata_nxt;
  logic [31:0]          rdata_r;

  always_comb begin
    rd_val = RDATA_ZERO;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (sel[i]) begin
        rd_val = stage_word(stage_r[i]);                               // [RULE_06]
      end
    end
    if (sel_status) begin
      rd_val = status_word;
    end

    // Captured in the setup cycle, held through the access phase
    rdata_nxt = rdata_r;
    if (rd_setup) begin
      rdata_nxt = rd_val;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RDATA_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Bus response and outputs
  // ==========================================================================
  // Zero wait states; unmapped or unaligned accesses are flagged
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = access_ph && !mapped;
    apb_rsp.prdata  = rdata_r;
  end

  // Filter side sees only registered state
  always_comb begin
    active_set     = set_r;                                            // [RULE_01]
    commit_pending = req_r;
  end

endmodule : notch_coef_shadow_regs

// [dv/notch_coef_shadow_regs_chk.sv]
/* Port checker for notch_coef_shadow_regs.
   Assumes one clock and binding to the top module. */
`timescale 1ns/10ps
module notch_chk
  import notch_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire notch_pkg::apb_req_t   apb_req,
  input wire notch_pkg::apb_rsp_t   apb_rsp,
  input wire logic                  sample_tick,
  input wire notch_pkg::notch_set_t active_set,
  input wire logic                  commit_pending
);
  // ==========================================================================
  // Helpers
  localparam logic [ADDR_W-1:0] NOTCH_LO = {IDX_A0_HIGH, 2'h0};
  localparam logic [ADDR_W-1:0] NOTCH_HI = {IDX_A1_LOW, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_AD  = {IDX_STATUS, 2'h0};
  wire logic acc   = apb_req.psel & apb_req.penable;
  wire logic rds   = apb_req.psel & !apb_req.penable & !apb_req.pwrite;
  wire logic in_rg = (apb_req.paddr >= NOTCH_LO) && (apb_req.paddr <= NOTCH_HI)
                     && (apb_req.paddr[1:0] == 2'h0);
  wire logic mapd  = in_rg || (apb_req.paddr == STAT_AD);
  wire logic wr    = acc & apb_req.pwrite & in_rg;
  wire logic cmt   = wr & apb_req.pwdata[COMMIT_BIT];
  wire logic apl   = sample_tick & commit_pending;
  // ==========================================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cmt; cmt; endsequence
  sequence s_apply; apl; endsequence
  chk_enable_reset: assert property ($rose(rst_n) |-> !active_set.enable)
    else $error("enable not clear");
  chk_zero_hold: assert property (!apl |=> $stable(active_set.coef_zero))
    else $error("coef zero moved");
  chk_one_hold: assert property (!apl |=> $stable(active_set.coef_one))
    else $error("coef one moved");
  chk_stage_only: assert property (wr && !cmt && !commit_pending |=> !commit_pending)
    else $error("staged write committed");
  chk_commit_sets: assert property (s_cmt |=> commit_pending)
    else $error("commit lost");
  chk_commit_wo: assert property (rds |=> !apb_rsp.prdata[COMMIT_BIT])
    else $error("commit bit read back");
  chk_tick_apply: assert property (s_apply ##0 !cmt |=> !commit_pending)
    else $error("tick did not apply");
  chk_set_moves: assert property ($changed(active_set) |-> $past(apl))
    else $error("active set moved off a tick");
  chk_pend_fall: assert property ($fell(commit_pending) |-> $past(sample_tick))
    else $error("pending dropped off a tick");
  chk_ready_high: assert property (apb_req.psel |-> apb_rsp.pready)
    else $error("wait state seen");
  chk_err_unmapped: assert property (acc && !mapd |-> apb_rsp.pslverr)
    else $error("unmapped access not flagged");
  chk_err_mapped: assert property (acc && mapd |-> !apb_rsp.pslverr)
    else $error("mapped access flagged");
endmodule : notch_chk
bind notch_coef_shadow_regs notch_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .sample_tick(sample_tick),
  .active_set(active_set), .commit_pending(commit_pending));

// [dv/tb_notch_coef_shadow_regs.sv]
/* Testbench for notch_coef_shadow_regs.
   Drives APB and sample_tick itself; no partner model. */
`timescale 1ns/10ps
module tb_notch_coef_shadow_regs;
  import notch_pkg::*;
  // ==========================================================================
  // Stimulus and checks
  logic       ref_clk = 0, rst_n = 0, sample_tick = 0, commit_pending, last_err;
  apb_req_t   apb_req = '0;
  apb_rsp_t   apb_rsp;
  notch_set_t active_set;
  int         n_fail = 0, checked = 0, cyc = 0;
  notch_coef_shadow_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .sample_tick(sample_tick), .active_set(active_set),
    .commit_pending(commit_pending));
  initial forever #5 ref_clk = ~ref_clk;
  task final_report;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(posedge ref_clk) if (++cyc == 3000) begin n_fail++; final_report(); end
  task cmp(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin n_fail++; $display("mismatch %s exp %h seen %h", n, e, s); end
  endtask : cmp
  task xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk) apb_req.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    last_err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge ref_clk);
  endtask : xfer
  task rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    cmp("prdata", q, e);
  endtask : rd
  task wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task tick;
    sample_tick <= 1'b1;
    @(posedge ref_clk) sample_tick <= 1'b0;
    @(posedge ref_clk);
  endtask : tick
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    cmp("active", 32'(active_set), 32'h0);
    for (int i = 0; i < 5; i++) rd(10'h06c + 10'(4 * i), 32'h0);
    wr(10'h06c, 32'h0d5);
    wr(10'h070, 32'h02a);
    wr(10'h074, 32'h013);
    cmp("pending", 32'(commit_pending), 32'h0);
    tick;
    cmp("active", 32'(active_set), 32'h0);
    rd(10'h06c, 32'h0d5);
    cmp("pslverr", 32'(last_err), 32'h0);
    wr(10'h078, 32'h17f);
    rd(10'h07c, 32'h1);
    rd(10'h078, 32'h07f);
    cmp("active", 32'(active_set), 32'h0);
    wr(10'h070, 32'h011);
    tick;
    cmp("active", 32'(active_set), {4'h1, 7'h55, 7'h2a, 7'h13, 7'h7f});
    rd(10'h07c, 32'h2);
    wr(10'h074, 32'h113);
    tick;
    cmp("active", 32'(active_set), {4'h1, 7'h55, 7'h11, 7'h13, 7'h7f});
    wr(10'h06c, 32'h155);
    tick;
    cmp("active", 32'(active_set), {4'h0, 7'h55, 7'h11, 7'h13, 7'h7f});
    wr(10'h06d, 32'h1ff);
    cmp("pslverr", 32'(last_err), 32'h1);
    rd(10'h06c, 32'h055);
    rd(10'h080, 32'h0);
    cmp("pslverr", 32'(last_err), 32'h1);
    cmp("pending", 32'(commit_pending), 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    cmp("active", 32'(active_set), 32'h0);
    rd(10'h074, 32'h0);
    final_report();
  end
endmodule : tb_notch_coef_shadow_regs
